// ### hw/cpu_control_register_set.sv
// CPU control register set: status word, page registers, base register, address forming
// How it works
// - Maskable interrupt accepted only when its level exceeds the three-bit mask.
// - Accepting level 1..7 loads that level into mask; NMI loads all ones.
// - Condition byte bits 7..4 ignore writes and read as zero.
// - Negative flag holds the sign bit of the updating result.
// - Zero flag is one on zero result, otherwise zero.
// - Overflow flag is one on arithmetic overflow, otherwise zero.
// - Carry flag set on carry or borrow, else cleared or kept.
// - Page registers affect addresses only in maximum mode.
// - Code page above program counter forms the fetch address; both saved and restored.
// - Data page supplies upper byte for registers 0..3 and word absolute.
// - Data page changes only through the load-control-register instruction or an APB write to its register.
// - Extended page supplies upper byte for registers 4 and 5.
// - Stack page supplies upper byte for registers 6, 7 and stack accesses.
// - Short absolute address is base byte over instruction byte, in page 0.
// - General, base and data, extended, stack pages need no reset value.
// - Reset loads program counter (and code page in max mode) from vector; mask all ones.
// - Mask sits in status bits 10..8; reset sets it to seven.
// - NMI counts as level 8, accepted at any mask.
// - Status bit 15 enables trace, raising trace after every instruction; reset clears.
// - Low status byte is accessible alone as the condition byte.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
module cpu_control_register_set (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // APB slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    input  wire logic [3:0]                 pstrb,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Mode pin and reset vector
    input  wire logic                       mode_max_pin,
    input  wire logic [15:0]                vector_pc,
    input  wire logic [7:0]                 vector_cp,
    // Execution datapath
    input  wire cpu_ctrl_pkg::flag_update_s flag_upd,
    input  wire logic                       ldc_data_page,
    input  wire logic [7:0]                 ldc_value,
    input  wire logic                       pc_load,
    input  wire logic [15:0]                pc_value,
    input  wire logic                       cp_load,
    input  wire logic [7:0]                 cp_value,
    input  wire logic                       insn_done,
    input  wire cpu_ctrl_pkg::addr_req_s    addr_req,
    input  wire logic [15:0]                greg_value,
    // Interrupt acceptance, trace, address and mode outputs
    input  wire cpu_ctrl_pkg::irq_req_s     irq,
    output logic                            irq_accept,
    output logic                            trace_req,
    output logic [23:0]                     fetch_addr,
    output logic [23:0]                     operand_addr,
    output logic [2:0]                      interrupt_mask,
    output logic                            mode_max
);
    // Mode strap through two flops; captured once after reset release
    logic       mode_sync1;
    logic       mode_sync2;
    logic       mode_captured;

    // No reset on the strap flops: they keep tracking the pin through reset, so
    // the vector load two edges after release sees a settled strap, not a cleared one
    always_ff @(posedge pclk) begin
        mode_sync1 <= mode_max_pin;
        mode_sync2 <= mode_sync1;
    end

    // Strap state machine: hold in capture until the synchroniser has settled
    typedef enum logic [2:0] {
        ST_SETTLE  = 3'b001,
        ST_VECTOR  = 3'b010,
        ST_RUN     = 3'b100
    } boot_e;
    boot_e boot_state;
    boot_e next_boot_state;

    always_comb begin
        case (boot_state)
            ST_SETTLE: next_boot_state = ST_VECTOR;
            ST_VECTOR: next_boot_state = ST_RUN;
            ST_RUN:    next_boot_state = ST_RUN;
            default:   next_boot_state = ST_SETTLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) boot_state <= ST_SETTLE;
        else          boot_state <= next_boot_state;
    end

    wire vector_load = (boot_state == ST_VECTOR);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)         mode_captured <= 1'b0;
        else if (vector_load) mode_captured <= mode_sync2;
    end

    // Registers
    logic        trace_en;
    logic [2:0]  mask;
    logic [3:0]  flags;
    logic [15:0] program_counter;
    logic [7:0]  code_page;
    logic [7:0]  data_page;
    logic [7:0]  extended_page;
    logic [7:0]  stack_page;
    logic [7:0]  short_address_base;

    // APB decode
    // A write lands only at the edge where the master samples pready high
    wire        apb_write  = psel && penable && pwrite && pready;
    wire        apb_read   = psel && penable && !pwrite;
    wire        hit_sw     = (paddr == cpu_ctrl_pkg::ADDR_STATUS_WORD);
    wire        hit_cf     = (paddr == cpu_ctrl_pkg::ADDR_COND_FLAGS);
    wire        hit_cp     = (paddr == cpu_ctrl_pkg::ADDR_CODE_PAGE);
    wire        hit_dp     = (paddr == cpu_ctrl_pkg::ADDR_DATA_PAGE);
    wire        hit_ep     = (paddr == cpu_ctrl_pkg::ADDR_EXT_PAGE);
    wire        hit_tp     = (paddr == cpu_ctrl_pkg::ADDR_STACK_PAGE);
    wire        hit_br     = (paddr == cpu_ctrl_pkg::ADDR_SHORT_BASE);
    wire        hit_pc     = (paddr == cpu_ctrl_pkg::ADDR_PROG_COUNTER);
    wire        hit_mode   = (paddr == cpu_ctrl_pkg::ADDR_MODE_CTRL);
    wire        hit_any    = hit_sw | hit_cf | hit_cp | hit_dp | hit_ep | hit_tp |
                             hit_br | hit_pc | hit_mode;
    wire        wr_lo      = apb_write && pstrb[0];
    wire        wr_hi      = apb_write && pstrb[1];

    // Interrupt acceptance
    wire        is_nmi     = (irq.level == cpu_ctrl_pkg::LEVEL_NMI);
    wire        level_ok   = irq.level[3] ? is_nmi : (irq.level[2:0] > mask);
    wire        accept     = irq.valid && (is_nmi || (level_ok && irq.level != 4'h0));
    wire [2:0]  accept_mask = is_nmi ? cpu_ctrl_pkg::MASK_ALL : irq.level[2:0];

    // Flag computation
    wire        res_msb    = flag_upd.word ? flag_upd.result[15] : flag_upd.result[7];
    wire        res_zero   = flag_upd.word ? (flag_upd.result == 16'h0000)
                                           : (flag_upd.result[7:0] == 8'h00);
    logic [3:0] next_flags;
    always_comb begin
        next_flags = flags;
        if (flag_upd.update) begin
            next_flags[cpu_ctrl_pkg::FLAG_NEG]  = res_msb;
            next_flags[cpu_ctrl_pkg::FLAG_ZERO] = res_zero;
            next_flags[cpu_ctrl_pkg::FLAG_OVF]  = flag_upd.overflow;
            if (flag_upd.carry || !flag_upd.carry_keep)
                next_flags[cpu_ctrl_pkg::FLAG_CARRY] = flag_upd.carry;
        end
        if (wr_lo && (hit_cf || hit_sw))
            next_flags = pwdata[3:0] & cpu_ctrl_pkg::FLAGS_WMASK;
    end

    // Status word: trace bit, mask, flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trace_en <= 1'b0;
            mask     <= cpu_ctrl_pkg::MASK_RESET;
            flags    <= cpu_ctrl_pkg::FLAGS_RESET;
        end else begin
            flags <= next_flags;
            if (accept)
                mask <= accept_mask;
            else if (wr_hi && hit_sw)
                mask <= pwdata[cpu_ctrl_pkg::MASK_MSB:cpu_ctrl_pkg::MASK_LSB];
            if (wr_hi && hit_sw)
                trace_en <= pwdata[cpu_ctrl_pkg::TRACE_BIT];
        end
    end

    // Program counter and code page: vector load at reset, then datapath or bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_counter <= cpu_ctrl_pkg::PC_RESET;
            code_page       <= cpu_ctrl_pkg::PAGE_RESET;
        end else if (vector_load) begin
            program_counter <= vector_pc;
            if (mode_sync2)
                code_page <= vector_cp;
        end else begin
            if (pc_load)
                program_counter <= pc_value;
            else if (apb_write && hit_pc)
                program_counter <= pwdata[15:0];
            if (cp_load)
                code_page <= cp_value;
            else if (wr_lo && hit_cp)
                code_page <= pwdata[7:0];
        end
    end

    // Page and base registers: no reset value needed, cleared for determinism
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_page          <= cpu_ctrl_pkg::PAGE_RESET;
            extended_page      <= cpu_ctrl_pkg::PAGE_RESET;
            stack_page         <= cpu_ctrl_pkg::PAGE_RESET;
            short_address_base <= cpu_ctrl_pkg::PAGE_RESET;
        end else begin
            if (ldc_data_page)
                data_page <= ldc_value;
            else if (wr_lo && hit_dp)
                data_page <= pwdata[7:0];
            if (wr_lo && hit_ep)
                extended_page <= pwdata[7:0];
            if (wr_lo && hit_tp)
                stack_page <= pwdata[7:0];
            if (wr_lo && hit_br)
                short_address_base <= pwdata[7:0];
        end
    end

    // Address generation
    function automatic logic [7:0] greg_page(input logic [2:0] r,
                                             input logic [7:0] dp,
                                             input logic [7:0] ep,
                                             input logic [7:0] tp);
        if (r[2] == 1'b0)   greg_page = dp;
        else if (!r[1])     greg_page = ep;
        else                greg_page = tp;
    endfunction

    logic [7:0]  op_page;
    logic [15:0] op_low;
    always_comb begin
        op_page = cpu_ctrl_pkg::PAGE_ZERO;
        op_low  = addr_req.offset;
        case (addr_req.src)
            cpu_ctrl_pkg::SRC_GREG:  begin
                op_page = greg_page(addr_req.greg, data_page, extended_page, stack_page);
                op_low  = greg_value;
            end
            cpu_ctrl_pkg::SRC_ABS16: op_page = data_page;
            cpu_ctrl_pkg::SRC_ABS8:  begin
                op_page = cpu_ctrl_pkg::PAGE_ZERO;
                op_low  = {short_address_base, addr_req.offset[7:0]};
            end
            cpu_ctrl_pkg::SRC_STACK: begin
                op_page = stack_page;
                op_low  = greg_value;
            end
            default: begin
                op_page = code_page;
                op_low  = program_counter;
            end
        endcase
        if (!mode_captured)
            op_page = cpu_ctrl_pkg::PAGE_ZERO;
    end

    wire [7:0] fetch_page = mode_captured ? code_page : cpu_ctrl_pkg::PAGE_ZERO;

    // Read mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (1'b1)
            hit_sw:   rd_mux = {16'h0000, trace_en, 4'h0, mask, 4'h0, flags};
            hit_cf:   rd_mux = {28'h0000000, flags};
            hit_cp:   rd_mux = {24'h000000, code_page};
            hit_dp:   rd_mux = {24'h000000, data_page};
            hit_ep:   rd_mux = {24'h000000, extended_page};
            hit_tp:   rd_mux = {24'h000000, stack_page};
            hit_br:   rd_mux = {24'h000000, short_address_base};
            hit_pc:   rd_mux = {16'h0000, program_counter};
            hit_mode: rd_mux = {31'h00000000, mode_captured};
            default:  rd_mux = 32'h0000_0000;
        endcase
    end

    // Registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata         <= 32'h0000_0000;
            pready         <= 1'b0;
            pslverr        <= 1'b0;
            irq_accept     <= 1'b0;
            trace_req      <= 1'b0;
            fetch_addr     <= 24'h000000;
            operand_addr   <= 24'h000000;
            interrupt_mask <= cpu_ctrl_pkg::MASK_RESET;
            mode_max       <= 1'b0;
        end else begin
            // One wait state: pready rises the cycle after penable
            pready         <= psel && penable && !pready;
            pslverr        <= psel && penable && !pready && !hit_any;
            prdata         <= (apb_read && !pready) ? rd_mux : prdata;
            irq_accept     <= accept;
            trace_req      <= trace_en && insn_done;
            fetch_addr     <= {fetch_page, program_counter};
            operand_addr   <= {op_page, op_low};
            interrupt_mask <= mask;
            mode_max       <= mode_captured;
        end
    end
endmodule // cpu_control_register_set

// ### hw/cpu_ctrl_pkg.sv
// Package: control register set offsets, field layouts, reset values and carriers
package cpu_ctrl_pkg;
    // APB register map (byte addresses)
    localparam logic [7:0] ADDR_STATUS_WORD   = 8'h00;
    localparam logic [7:0] ADDR_COND_FLAGS    = 8'h04;
    localparam logic [7:0] ADDR_CODE_PAGE     = 8'h08;
    localparam logic [7:0] ADDR_DATA_PAGE     = 8'h0c;
    localparam logic [7:0] ADDR_EXT_PAGE      = 8'h10;
    localparam logic [7:0] ADDR_STACK_PAGE    = 8'h14;
    localparam logic [7:0] ADDR_SHORT_BASE    = 8'h18;
    localparam logic [7:0] ADDR_PROG_COUNTER  = 8'h1c;
    localparam logic [7:0] ADDR_MODE_CTRL     = 8'h20;

    // Status word and mode control fields
    localparam int TRACE_BIT     = 15;
    localparam int MASK_LSB      = 8;
    localparam int MASK_MSB      = 10;
    localparam int FLAG_NEG      = 3;
    localparam int FLAG_ZERO     = 2;
    localparam int FLAG_OVF      = 1;
    localparam int FLAG_CARRY    = 0;
    localparam int MODE_MAX_BIT  = 0;

    localparam logic [2:0]  MASK_RESET   = 3'h7;
    localparam logic [2:0]  MASK_ALL     = 3'h7;
    localparam logic [3:0]  LEVEL_NMI    = 4'h8;
    localparam logic [3:0]  FLAGS_RESET  = 4'h0;
    localparam logic [3:0]  FLAGS_WMASK  = 4'hf;
    localparam logic [7:0]  PAGE_ZERO    = 8'h00;
    localparam logic [7:0]  PAGE_RESET   = 8'h00;
    localparam logic [15:0] PC_RESET     = 16'h0000;

    // Address source select from the execution datapath
    typedef enum logic [2:0] {
        SRC_FETCH   = 3'h0,
        SRC_GREG    = 3'h1,
        SRC_ABS16   = 3'h2,
        SRC_ABS8    = 3'h3,
        SRC_STACK   = 3'h4
    } addr_src_e;

    // Flag update request from the ALU
    typedef struct packed {
        logic        update;
        logic [15:0] result;
        logic        word;
        logic        overflow;
        logic        carry;
        logic        carry_keep;
    } flag_update_s;

    // Address generation request
    typedef struct packed {
        addr_src_e   src;
        logic [2:0]  greg;
        logic [15:0] offset;
    } addr_req_s;

    // Interrupt request to the acceptance logic
    typedef struct packed {
        logic       valid;
        logic [3:0] level;
    } irq_req_s;
endpackage

// ### bench/cpu_ctrl_assertions.sv
// Port-level checks for the control register set
module cpu_ctrl_assertions (
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire logic                    insn_done,
    input wire logic                    trace_req,
    input wire cpu_ctrl_pkg::irq_req_s  irq,
    input wire logic                    irq_accept,
    input wire logic [2:0]              interrupt_mask,
    input wire logic                    mode_max,
    input wire cpu_ctrl_pkg::addr_req_s addr_req,
    input wire logic [15:0]             greg_value,
    input wire logic [23:0]             fetch_addr,
    input wire logic [23:0]             operand_addr
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_ACCEPT_RULE: assert property ($past(presetn) |-> irq_accept ==
        ($past(irq.valid) && ($past(irq.level) == 4'h8 || $past(irq.level) > {1'b0, interrupt_mask})))
        else $error("accept decision wrong");
    AST_NMI_TAKEN: assert property (irq.valid && irq.level == 4'h8 |=> irq_accept)
        else $error("nmi refused");
    AST_MASK_LOAD: assert property (irq_accept |=> interrupt_mask ==
        ($past(irq.level, 2) == 4'h8 ? 3'h7 : $past(irq.level[2:0], 2)))
        else $error("mask not loaded");
    AST_TRACE_CAUSE: assert property (trace_req |-> $past(insn_done))
        else $error("trace without instruction");
    AST_MIN_PAGE: assert property (!mode_max && $past(!mode_max) && $past(presetn) |->
        fetch_addr[23:16] == 8'h00 && operand_addr[23:16] == 8'h00)
        else $error("page used in minimum mode");
    AST_SHORT_ABS: assert property ($past(presetn) &&
        $past(addr_req.src) == cpu_ctrl_pkg::SRC_ABS8 |->
        operand_addr[23:16] == 8'h00 && operand_addr[7:0] == $past(addr_req.offset[7:0]))
        else $error("short absolute address wrong");
    AST_LOW_WORD: assert property ($past(presetn) && $past(addr_req.src) inside
        {cpu_ctrl_pkg::SRC_GREG, cpu_ctrl_pkg::SRC_ABS16, cpu_ctrl_pkg::SRC_STACK} |->
        operand_addr[15:0] == ($past(addr_req.src) == cpu_ctrl_pkg::SRC_ABS16 ?
        $past(addr_req.offset) : $past(greg_value)))
        else $error("operand low word wrong");
endmodule // cpu_ctrl_assertions

// ### bench/cpu_datapath_model.sv
// Datapath model: forms ALU results and flag causes for the flag port
module cpu_datapath_model (
    input  wire logic                  go,
    input  wire logic [15:0]           a,
    input  wire logic [15:0]           b,
    input  wire logic                  sub,
    input  wire logic                  keep,
    output cpu_ctrl_pkg::flag_update_s flag_upd
);
    logic [16:0] sum;
    logic        ovf;
    assign sum = sub ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
    // Sign clash only when operand signs agree for add, differ for subtract
    assign ovf = ((a[15] ^ b[15]) == sub) && (sum[15] != a[15]);
    assign flag_upd = '{go, sum[15:0], 1'b1, ovf, sum[16] & ~keep, keep};
endmodule // cpu_datapath_model

// ### bench/cpu_control_register_set_bench.sv
// Self-checking bench for the control register set
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module cpu_control_register_set_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk;
    logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, ldc_value = 8'h00, cp_value = 8'h00, vector_cp = 8'h5a;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] pstrb = 4'h0;
    logic [15:0] vector_pc = 16'h4321, pc_value = 16'h0, greg_value = 16'hbeef;
    logic [15:0] a = 16'h0, b = 16'h0;
    logic mode_max_pin = 1'b1, ldc_data_page = 1'b0, pc_load = 1'b0, cp_load = 1'b0;
    logic insn_done = 1'b0, go = 1'b0, sub = 1'b0, keep = 1'b0;
    logic pready, pslverr, irq_accept, trace_req, mode_max;
    logic [23:0] fetch_addr, operand_addr;
    logic [2:0] interrupt_mask;
    cpu_ctrl_pkg::flag_update_s flag_upd;
    cpu_ctrl_pkg::addr_req_s addr_req = '{cpu_ctrl_pkg::SRC_FETCH, 3'h0, 16'h0};
    cpu_ctrl_pkg::irq_req_s irq = '{1'b0, 4'h0};
    int err_total = 0;
    int checked = 0;
    cpu_control_register_set i_cpu_control_register_set (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .mode_max_pin,
        .vector_pc, .vector_cp, .flag_upd, .ldc_data_page, .ldc_value, .pc_load, .pc_value,
        .cp_load, .cp_value, .insn_done, .addr_req, .greg_value, .irq, .irq_accept,
        .trace_req, .fetch_addr, .operand_addr, .interrupt_mask, .mode_max);
    cpu_datapath_model i_cpu_datapath_model (.go, .a, .b, .sub, .keep, .flag_upd);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that is never answered
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        logic e;
        apb(1'b1, ad, d, s, r, e);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, ad, 32'h0, 4'h0, r, e);
        `CHK($sformatf("reg %h", ad), x, r)
    endtask
    task automatic do_reset(input logic mp);
        presetn <= 1'b0;
        mode_max_pin <= mp;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask
    task automatic chk_addr(input cpu_ctrl_pkg::addr_src_e s, input logic [2:0] g,
                            input logic [23:0] x);
        addr_req <= '{s, g, 16'hc0de};
        repeat (2) @(posedge pclk);
        `CHK("operand", x, operand_addr)
    endtask
    task automatic t_boot;
        logic [31:0] r;
        logic e;
        rd(cpu_ctrl_pkg::ADDR_STATUS_WORD, 32'h700);
        rd(cpu_ctrl_pkg::ADDR_PROG_COUNTER, 32'h4321);
        rd(cpu_ctrl_pkg::ADDR_CODE_PAGE, 32'h5a);
        rd(cpu_ctrl_pkg::ADDR_MODE_CTRL, 32'h1);
        `CHK("mode", 1'b1, mode_max)
        apb(1'b0, 8'h24, 32'h0, 4'h0, r, e);
        `CHK("unmapped err", 1'b1, e)
        `CHK("unmapped data", 32'h0, r)
        wr(cpu_ctrl_pkg::ADDR_COND_FLAGS, 32'hffffffff, 4'hf);
        rd(cpu_ctrl_pkg::ADDR_COND_FLAGS, 32'hf);
        rd(cpu_ctrl_pkg::ADDR_STATUS_WORD, 32'h70f);
    endtask
    task automatic t_flags;
        logic [15:0] av [5] = '{16'hffff, 16'h1, 16'h7fff, 16'h1, 16'h0};
        logic [1:0] md [5] = '{2'h0, 2'h2, 2'h0, 2'h1, 2'h1};
        logic [3:0] fx [5] = '{4'h5, 4'h1, 4'ha, 4'h4, 4'h9};
        for (int i = 0; i < 5; i++) begin
            a <= av[i];
            b <= 16'h1;
            sub <= md[i][0];
            keep <= md[i][1];
            go <= 1'b1;
            @(posedge pclk);
            go <= 1'b0;
            rd(cpu_ctrl_pkg::ADDR_COND_FLAGS, {28'h0, fx[i]});
        end
    endtask
    task automatic t_irq;
        logic [2:0] m;
        logic x;
        for (int k = 0; k < 3; k++) begin
            for (int l = 0; l < 9; l++) begin
                m = (k == 0) ? 3'h0 : (k == 1) ? 3'h3 : 3'h7;
                x = (l == 8) || (l > m);
                wr(cpu_ctrl_pkg::ADDR_STATUS_WORD, {21'h0, m, 8'h0}, 4'h2);
                irq <= '{1'b1, 4'(l)};
                @(posedge pclk);
                irq <= '{1'b0, 4'h0};
                @(posedge pclk);
                `CHK("accept", x, irq_accept)
                @(posedge pclk);
                `CHK("mask", x ? ((l == 8) ? 3'h7 : 3'(l)) : m, interrupt_mask)
            end
        end
    endtask
    task automatic t_trace;
        for (int t = 1; t >= 0; t--) begin
            wr(cpu_ctrl_pkg::ADDR_STATUS_WORD, {16'h0, 1'(t), 15'h0}, 4'h2);
            insn_done <= 1'b1;
            @(posedge pclk);
            insn_done <= 1'b0;
            @(posedge pclk);
            `CHK("trace", 1'(t), trace_req)
        end
    endtask
    task automatic t_pages;
        logic [7:0] pa [5] = '{cpu_ctrl_pkg::ADDR_STACK_PAGE, cpu_ctrl_pkg::ADDR_CODE_PAGE,
            cpu_ctrl_pkg::ADDR_DATA_PAGE, cpu_ctrl_pkg::ADDR_EXT_PAGE,
            cpu_ctrl_pkg::ADDR_SHORT_BASE};
        logic [7:0] pv [5] = '{8'h44, 8'h11, 8'h22, 8'h33, 8'h55};
        // Stack page goes first and the base before any short absolute use
        for (int i = 0; i < 5; i++) begin
            wr(pa[i], {24'h0, pv[i]}, 4'h1);
            rd(pa[i], {24'h0, pv[i]});
        end
        wr(cpu_ctrl_pkg::ADDR_PROG_COUNTER, 32'h1234, 4'h3);
        @(posedge pclk);
        `CHK("fetch", 24'h111234, fetch_addr)
        chk_addr(cpu_ctrl_pkg::SRC_GREG, 3'h1, 24'h22beef);
        chk_addr(cpu_ctrl_pkg::SRC_GREG, 3'h4, 24'h33beef);
        chk_addr(cpu_ctrl_pkg::SRC_GREG, 3'h7, 24'h44beef);
        chk_addr(cpu_ctrl_pkg::SRC_ABS16, 3'h0, 24'h22c0de);
        chk_addr(cpu_ctrl_pkg::SRC_ABS8, 3'h0, 24'h0055de);
        chk_addr(cpu_ctrl_pkg::SRC_STACK, 3'h6, 24'h44beef);
        ldc_value <= 8'h66;
        ldc_data_page <= 1'b1;
        @(posedge pclk);
        ldc_data_page <= 1'b0;
        ldc_value <= 8'h77;
        chk_addr(cpu_ctrl_pkg::SRC_GREG, 3'h0, 24'h66beef);
        pc_value <= 16'habcd;
        cp_value <= 8'h9a;
        pc_load <= 1'b1;
        cp_load <= 1'b1;
        @(posedge pclk);
        pc_load <= 1'b0;
        cp_load <= 1'b0;
        repeat (2) @(posedge pclk);
        `CHK("restore", 24'h9aabcd, fetch_addr)
    endtask
    task automatic t_min;
        do_reset(1'b0);
        chk_addr(cpu_ctrl_pkg::SRC_STACK, 3'h7, 24'h00beef);
        rd(cpu_ctrl_pkg::ADDR_MODE_CTRL, 32'h0);
        `CHK("mode", 1'b0, mode_max)
        wr(cpu_ctrl_pkg::ADDR_CODE_PAGE, 32'h11, 4'h1);
        wr(cpu_ctrl_pkg::ADDR_DATA_PAGE, 32'h22, 4'h1);
        `CHK("min fetch", 8'h00, fetch_addr[23:16])
        chk_addr(cpu_ctrl_pkg::SRC_GREG, 3'h1, 24'h00beef);
    endtask
    task automatic complete_run;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        do_reset(1'b1);
        t_boot;
        t_flags;
        t_irq;
        t_trace;
        t_pages;
        t_min;
        complete_run;
    end
    // The whole run needs a few hundred cycles; this only cuts a hang
    initial begin
        #100000;
        err_total++;
        complete_run;
    end
endmodule // cpu_control_register_set_bench
bind cpu_control_register_set cpu_ctrl_assertions i_cpu_ctrl_assertions (.pclk, .presetn,
    .psel, .penable, .pready, .pslverr, .insn_done, .trace_req, .irq, .irq_accept,
    .interrupt_mask, .mode_max, .addr_req, .greg_value, .fetch_addr, .operand_addr);
